// [rtl/frs_regs.svh]
// constants of the fault restart supervisor
`ifndef FRS_REGS_SVH
`define FRS_REGS_SVH

// clock rate and derived cycle counts
`define FRS_CLK_HZ        64'd200000000
`define FRS_SEC_S         64'd1
`define FRS_SKIP_HOLD_S   64'd1
`define FRS_CLR_HOLD_S    64'd3
`define FRS_VIN_HI_S      64'd10
`define FRS_SEC_CYC       (`FRS_SEC_S * `FRS_CLK_HZ)
`define FRS_SKIP_CYC      (`FRS_SKIP_HOLD_S * `FRS_CLK_HZ)
`define FRS_CLR_CYC       (`FRS_CLR_HOLD_S * `FRS_CLK_HZ)
`define FRS_VIN_HI_CYC    (`FRS_VIN_HI_S * `FRS_CLK_HZ)

// voltage limits, volts, and bus unbalance, percent
`define FRS_VIN_HI_LV     10'd264
`define FRS_VIN_HI_HV     10'd520
`define FRS_BUS_OV_LV     10'd470
`define FRS_BUS_OV_HV     10'd930
`define FRS_UNBAL_PCT     14'd10

// fault bit positions
`define FRS_F_ALARM       0
`define FRS_F_LATCH1      1
`define FRS_F_LATCH4      4
`define FRS_F_PIPE        5
`define FRS_F_BUS_OV      6
`define FRS_F_BUS_UNBAL   7
`define FRS_F_COMM        8
`define FRS_F_CUR_UNBAL   9
`define FRS_F_GROUND      10
`define FRS_F_VIN_HI      11
`define FRS_F_PHASE       12
`define FRS_F_CM_CONN     13
`define FRS_F_PRECHARGE   14
`define FRS_F_VIN_LO      15
`define FRS_NFAULT        16

// faults that never restart on their own
`define FRS_NOAUTO_MASK   16'h241E
// reset values
`define FRS_RST_LIMIT     4'h0
`define FRS_RST_CODE      4'hF

`endif

// [rtl/frs_pkg.sv]
// types of the fault restart supervisor
package frs_pkg;
	typedef enum logic [4:0] {
		FRS_INIT   = 5'h01,
		FRS_RUN    = 5'h02,
		FRS_CNTDN  = 5'h04,
		FRS_PROMPT = 5'h08,
		FRS_NOAUTO = 5'h10
	} frs_state_e;

	typedef logic [15:0] frs_fault_t;
endpackage : frs_pkg

// [rtl/frs_sync.sv]
// two flop synchroniser for pin inputs
`timescale 1ns/1ps
module frs_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         ce,
	// pin side
	input  wire logic [W-1:0] pin_in,
	// synchronised side
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else if (ce) begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule : frs_sync

// [rtl/frs_hold_timer.sv]
// counts how long a level has stood, flags once a limit is reached
`timescale 1ns/1ps
module frs_hold_timer #(
	parameter logic [31:0] LIMIT = 32'h0000_0010
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic ce,
	// watched level and result
	input  wire logic lvl,
	output logic      done
);
	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	wire         at_lim = (cnt_ff >= LIMIT);

	// saturates so a long hold cannot wrap and re-arm
	assign nxt_cnt = !lvl ? 32'h0000_0000 : (at_lim ? cnt_ff : cnt_ff + 32'h0000_0001);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= 32'h0000_0000;
		end else if (ce) begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign done = lvl & at_lim;
endmodule : frs_hold_timer

// [rtl/frs_supervisor.sv]
// fault latch, restart countdown and clearing paths of the drive
`timescale 1ns/1ps
`include "frs_regs.svh"
//
// Function
// - restartable fault shows pending and countdown
// - up and down held skips countdown
// - restart limit resets to zero
// - restart limit and delay are programmable
// - used up or disabled shows enter prompt
// - enter clears fault, restarts, zeroes log
// - enable gates restart, sets auto mode
// - severe faults show no auto restart
// - severe faults clear by power or hold
// - init conditions shown, not logged, awaited
// - same conditions later are logged faults
// - dry contact closure latches, never restarts
// - alarm set as fault raises fault
// - input over limit ten seconds faults
// - bus over limit trips at once
// - bus halves differing over ten percent
// - board link failure raises fault
// - current unbalance over limit faults
// - setpoint not reached beyond threshold faults
// - ground fault sensitivity, never restarts
// - measurement board cable loss, no restart
// - phase loss faults unless single phase
// - restart counter cleared by power cycle
module frs_supervisor #(
	parameter logic [31:0] SEC_CYC    = 32'(`FRS_SEC_CYC),
	parameter logic [31:0] SKIP_CYC   = 32'(`FRS_SKIP_CYC),
	parameter logic [31:0] CLR_CYC    = 32'(`FRS_CLR_CYC),
	parameter logic [31:0] VIN_HI_CYC = 32'(`FRS_VIN_HI_CYC)
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	// keypad pins
	input  wire logic        key_up,
	input  wire logic        key_down,
	input  wire logic        key_enter,
	// dry contact pins, high when closed
	input  wire logic        dry_contact_input_1,
	input  wire logic        dry_contact_input_2,
	input  wire logic        dry_contact_input_3,
	input  wire logic        dry_contact_input_4,
	// measurements and detector flags
	input  wire logic        hv_variant,
	input  wire logic [9:0]  vin_rms,
	input  wire logic        vin_low,
	input  wire logic [9:0]  bus_vdc,
	input  wire logic [9:0]  bus_upper,
	input  wire logic [9:0]  bus_lower,
	input  wire logic        precharge_fail,
	input  wire logic        comm_fail,
	input  wire logic        cm_cable_lost,
	input  wire logic        phase_loss,
	input  wire logic [7:0]  gf_level,
	input  wire logic [7:0]  cur_unbal_pct,
	input  wire logic        at_max_speed,
	input  wire logic [9:0]  pressure,
	input  wire logic [9:0]  setpoint,
	input  wire logic [3:0]  alarm_evt,
	// configuration
	input  wire logic        restart_enable,
	input  wire logic [3:0]  auto_restart_limit,
	input  wire logic [7:0]  restart_delay_s,
	input  wire logic [7:0]  gf_sensitivity,
	input  wire logic [7:0]  current_unbalance_limit,
	input  wire logic [9:0]  broken_pipe_threshold,
	input  wire logic        single_phase_supply_permit,
	input  wire logic [3:0]  alarm_as_fault,
	input  wire logic [3:0]  log_sel,
	// status and display
	output logic             run_enable,
	output logic             auto_mode,
	output logic             init_fault,
	output logic             restart_pending,
	output logic [7:0]       countdown_s,
	output logic             prompt_enter,
	output logic             no_auto_msg,
	output logic [3:0]       fault_code,
	output logic [15:0]      fault_latched,
	output logic [3:0]       restart_count,
	output logic [7:0]       log_count
);
	frs_pkg::frs_state_e state_ff;
	frs_pkg::frs_state_e nxt_state;
	frs_pkg::frs_fault_t flt_ff;
	frs_pkg::frs_fault_t nxt_flt;
	frs_pkg::frs_fault_t det;
	logic [7:0]          log_ff [`FRS_NFAULT];
	logic [3:0]          rcnt_ff;
	logic [7:0]          cdn_ff;
	logic [31:0]         tick_ff;
	logic                auto_ff;
	logic                enter_d_ff;
	logic [3:0]          code_ff;
	logic [6:0]          pins_s;

	// volts at or over the variant limit
	function automatic logic over_lim(input logic [9:0] v, input logic [9:0] lo,
		input logic [9:0] hi, input logic hv);
		over_lim = hv ? (v >= hi) : (v >= lo);
	endfunction : over_lim

	// lowest set fault bit, or all ones if none
	function automatic logic [3:0] first_set(input frs_pkg::frs_fault_t f);
		first_set = `FRS_RST_CODE;
		for (int i = `FRS_NFAULT - 1; i >= 0; i--) begin
			if (f[i]) begin
				first_set = 4'(i);
			end
		end
	endfunction : first_set

	frs_sync #(
		.W(7)
	) u_sync (
		.clk      (clk),
		.rstn     (rstn),
		.ce       (ce),
		.pin_in   ({dry_contact_input_4, dry_contact_input_3, dry_contact_input_2,
		            dry_contact_input_1, key_enter, key_down, key_up}),
		.sync_out (pins_s)
	);

	wire       up_s    = pins_s[0];
	wire       down_s  = pins_s[1];
	wire       enter_s = pins_s[2];
	wire [3:0] dry_s   = pins_s[6:3];
	wire       both_s  = up_s & down_s;
	wire       enter_p = enter_s & ~enter_d_ff;

	// input above limit for ten seconds, sitting on it is legal
	wire vin_over = over_lim(vin_rms, `FRS_VIN_HI_LV + 10'd1, `FRS_VIN_HI_HV + 10'd1,
		hv_variant);
	wire vin_hi_long;
	wire skip_hold;
	wire clr_hold;

	frs_hold_timer #(
		.LIMIT(VIN_HI_CYC)
	) u_vin_hi (
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.lvl  (vin_over),
		.done (vin_hi_long)
	);

	// short hold only counts inside a countdown
	frs_hold_timer #(
		.LIMIT(SKIP_CYC)
	) u_skip (
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.lvl  (both_s & (state_ff == frs_pkg::FRS_CNTDN)),
		.done (skip_hold)
	);

	frs_hold_timer #(
		.LIMIT(CLR_CYC)
	) u_clr (
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.lvl  (both_s & (state_ff == frs_pkg::FRS_NOAUTO)),
		.done (clr_hold)
	);

	// bus halves: a hundred times the gap against the percent times the larger half
	wire [9:0]  bus_big  = (bus_upper > bus_lower) ? bus_upper : bus_lower;
	wire [9:0]  bus_gap  = (bus_upper > bus_lower) ? (bus_upper - bus_lower)
	                                               : (bus_lower - bus_upper);
	wire [16:0] gap_x100 = 17'(bus_gap) * 17'h00064;
	wire [16:0] big_xpct = 17'(bus_big) * 17'(`FRS_UNBAL_PCT);
	wire [10:0] need_p   = 11'(pressure) + 11'(broken_pipe_threshold);

	assign det[`FRS_F_ALARM] = |(alarm_evt & alarm_as_fault);
	assign det[`FRS_F_LATCH4:`FRS_F_LATCH1] = dry_s;
	assign det[`FRS_F_PIPE] = at_max_speed & (need_p < 11'(setpoint));
	assign det[`FRS_F_BUS_OV] = over_lim(bus_vdc, `FRS_BUS_OV_LV, `FRS_BUS_OV_HV, hv_variant);
	assign det[`FRS_F_BUS_UNBAL] = gap_x100 > big_xpct;
	assign det[`FRS_F_COMM] = comm_fail;
	assign det[`FRS_F_CUR_UNBAL] = cur_unbal_pct > current_unbalance_limit;
	assign det[`FRS_F_GROUND] = gf_level >= gf_sensitivity;
	assign det[`FRS_F_VIN_HI] = vin_hi_long;
	assign det[`FRS_F_PHASE] = phase_loss & ~single_phase_supply_permit;
	assign det[`FRS_F_CM_CONN] = cm_cable_lost;
	assign det[`FRS_F_PRECHARGE] = precharge_fail;
	assign det[`FRS_F_VIN_LO] = vin_low;

	wire init_cond = det[`FRS_F_GROUND] | det[`FRS_F_PRECHARGE] | vin_hi_long | vin_low;
	wire in_init   = (state_ff == frs_pkg::FRS_INIT);
	wire any_flt   = |flt_ff;
	wire severe    = |(flt_ff & `FRS_NOAUTO_MASK);
	wire may_auto  = restart_enable & (rcnt_ff < auto_restart_limit);
	wire cd_zero   = (cdn_ff == 8'h00);
	wire sec_tick  = (tick_ff == SEC_CYC - 32'h0000_0001);

	wire cd_done   = (state_ff == frs_pkg::FRS_CNTDN) & (skip_hold | cd_zero);
	wire prm_done  = (state_ff == frs_pkg::FRS_PROMPT) & enter_p;
	wire sev_done  = (state_ff == frs_pkg::FRS_NOAUTO) & clr_hold;
	wire clr_all   = cd_done | prm_done | sev_done;
	wire log_clr   = prm_done;
	wire go_fault  = (state_ff == frs_pkg::FRS_RUN) & any_flt;
	wire cd_load   = go_fault & ~severe & may_auto;

	// later conditions latch; a new event outlives a clear
	assign nxt_flt = in_init ? flt_ff : ((flt_ff & ~{16{clr_all}}) | det);
	wire [15:0] new_evt = in_init ? 16'h0000 : (det & ~flt_ff);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			frs_pkg::FRS_INIT: begin
				if (!init_cond) begin
					nxt_state = frs_pkg::FRS_RUN;
				end
			end
			frs_pkg::FRS_RUN: begin
				if (any_flt) begin
					if (severe) begin
						nxt_state = frs_pkg::FRS_NOAUTO;
					end else if (may_auto) begin
						nxt_state = frs_pkg::FRS_CNTDN;
					end else begin
						nxt_state = frs_pkg::FRS_PROMPT;
					end
				end
			end
			frs_pkg::FRS_CNTDN: begin
				if (|(flt_ff & `FRS_NOAUTO_MASK)) begin
					nxt_state = frs_pkg::FRS_NOAUTO;
				end else if (cd_done) begin
					nxt_state = frs_pkg::FRS_RUN;
				end
			end
			frs_pkg::FRS_PROMPT: begin
				if (severe) begin
					nxt_state = frs_pkg::FRS_NOAUTO;
				end else if (prm_done) begin
					nxt_state = frs_pkg::FRS_RUN;
				end
			end
			frs_pkg::FRS_NOAUTO: begin
				if (sev_done) begin
					nxt_state = frs_pkg::FRS_RUN;
				end
			end
			default: begin
				nxt_state = frs_pkg::FRS_INIT;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff   <= frs_pkg::FRS_INIT;
			flt_ff     <= 16'h0000;
			enter_d_ff <= 1'b0;
		end else if (ce) begin
			state_ff   <= nxt_state;
			flt_ff     <= nxt_flt;
			enter_d_ff <= enter_s;
		end
	end

	// auto mode taken at init exit
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			auto_ff <= 1'b0;
		end else if (ce && in_init && !init_cond) begin
			auto_ff <= restart_enable;
		end
	end

	// counter zeroed only by power up
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rcnt_ff <= `FRS_RST_LIMIT;
		end else if (ce && cd_done && rcnt_ff != 4'hF) begin
			rcnt_ff <= rcnt_ff + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cdn_ff  <= 8'h00;
			tick_ff <= 32'h0000_0000;
		end else if (ce) begin
			if (cd_load) begin
				cdn_ff  <= restart_delay_s;
				tick_ff <= 32'h0000_0000;
			end else if (state_ff == frs_pkg::FRS_CNTDN) begin
				tick_ff <= sec_tick ? 32'h0000_0000 : tick_ff + 32'h0000_0001;
				if (sec_tick && !cd_zero) begin
					cdn_ff <= cdn_ff - 8'h01;
				end
			end
		end
	end

	// restart log, one saturating counter per fault
	for (genvar g = 0; g < `FRS_NFAULT; g++) begin : g_log
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				log_ff[g] <= 8'h00;
			end else if (ce) begin
				if (new_evt[g]) begin
					log_ff[g] <= log_clr ? 8'h01 : log_ff[g] + {7'h00, log_ff[g] != 8'hFF};
				end else if (log_clr) begin
					log_ff[g] <= 8'h00;
				end
			end
		end
	end

	// display code follows init conditions or latched faults
	wire [3:0] nxt_code = in_init ? first_set(det & 16'hCC00) : first_set(flt_ff);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			code_ff <= `FRS_RST_CODE;
		end else if (ce) begin
			code_ff <= nxt_code;
		end
	end

	// output drive is off while any fault stands
	assign run_enable      = (state_ff == frs_pkg::FRS_RUN) & ~any_flt;
	assign auto_mode       = auto_ff;
	assign init_fault      = in_init & init_cond;
	assign restart_pending = (state_ff == frs_pkg::FRS_CNTDN);
	assign countdown_s     = cdn_ff;
	assign prompt_enter    = (state_ff == frs_pkg::FRS_PROMPT);
	assign no_auto_msg     = (state_ff == frs_pkg::FRS_NOAUTO);
	assign fault_code      = code_ff;
	assign fault_latched   = flt_ff;
	assign restart_count   = rcnt_ff;
	assign log_count       = log_ff[log_sel];
endmodule : frs_supervisor

// [verif/frs_monitor.sv]
// concurrent checks on the fault restart supervisor ports
`timescale 1ns/1ps
module frs_monitor #(
	parameter logic [31:0] CLR_CYC = 32'h0000_001E
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// keys and configuration
	input wire logic        key_up,
	input wire logic        key_down,
	input wire logic        restart_enable,
	input wire logic [3:0]  auto_restart_limit,
	input wire logic [7:0]  restart_delay_s,
	// status
	input wire logic        run_enable,
	input wire logic        init_fault,
	input wire logic        restart_pending,
	input wire logic [7:0]  countdown_s,
	input wire logic        prompt_enter,
	input wire logic        no_auto_msg,
	input wire logic [15:0] fault_latched,
	input wire logic [3:0]  restart_count,
	input wire logic [7:0]  log_count
);
	logic [31:0] hold_ff;
	logic        seen_ff;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// raw hold count leads the synced one, so margin of two
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hold_ff <= 32'h0;
			seen_ff <= 1'b0;
		end else begin
			hold_ff <= (key_up && key_down) ? hold_ff + 32'h1 : 32'h0;
			seen_ff <= no_auto_msg && (seen_ff || hold_ff + 32'h2 >= CLR_CYC);
		end
	end
	cnt_load_a: assert property ($rose(restart_pending) |-> countdown_s == restart_delay_s)
		else $error("countdown not loaded with delay");
	cnt_step_a: assert property (restart_pending && $past(restart_pending)
		&& countdown_s != $past(countdown_s) |-> countdown_s == $past(countdown_s) - 8'h1)
		else $error("countdown skipped a second");
	auto_gate_a: assert property ($rose(restart_pending) |-> $past(restart_enable)
		&& $past(restart_count) < $past(auto_restart_limit))
		else $error("countdown without restarts left");
	prompt_gate_a: assert property ($rose(prompt_enter) |-> !$past(restart_enable)
		|| $past(restart_count) >= $past(auto_restart_limit))
		else $error("prompt while restarts left");
	count_step_a: assert property ($fell(restart_pending) && !no_auto_msg && !prompt_enter
		|-> restart_count == $past(restart_count) + 4'h1)
		else $error("restart not counted");
	severe_goes_a: assert property (|(fault_latched & 16'h241E) && !no_auto_msg
		|=> no_auto_msg)
		else $error("severe fault without no restart message");
	hold_exit_a: assert property (no_auto_msg && !seen_ff |=> no_auto_msg)
		else $error("severe state left without long hold");
	fault_off_a: assert property (|fault_latched |-> !run_enable)
		else $error("drive on with latched fault");
	init_quiet_a: assert property (init_fault |-> fault_latched == 16'h0 && !run_enable)
		else $error("init condition latched or drive on");
	log_clear_a: assert property ($fell(prompt_enter) && !no_auto_msg |-> log_count == 8'h0)
		else $error("log not cleared by enter");
	cover property ($rose(restart_pending));
	cover property ($rose(no_auto_msg));
	cover property ($fell(prompt_enter));
endmodule : frs_monitor

bind frs_supervisor frs_monitor #(.CLR_CYC(CLR_CYC)) u_mon (.clk, .rstn, .key_up, .key_down,
	.restart_enable, .auto_restart_limit, .restart_delay_s, .run_enable, .init_fault,
	.restart_pending, .countdown_s, .prompt_enter, .no_auto_msg, .fault_latched,
	.restart_count, .log_count);

// [verif/frs_operator.sv]
// keypad operator and dry contact switches
`timescale 1ns/1ps
module frs_operator (
	// clock
	input wire logic  clk,
	// keypad and contact pins, released keys and open contacts read low
	output logic      key_up,
	output logic      key_down,
	output logic      key_enter,
	output logic [3:0] contact
);
	initial begin
		{key_up, key_down, key_enter} = 3'h0;
		contact = 4'h0;
	end
	task automatic hold_both(input int n);
		@(posedge clk);
		#1;
		{key_up, key_down} = 2'h3;
		repeat (n) @(posedge clk);
		#1;
		{key_up, key_down} = 2'h0;
	endtask : hold_both
	task automatic press_enter();
		@(posedge clk);
		#1;
		key_enter = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		key_enter = 1'b0;
	endtask : press_enter
	task automatic close(input int i);
		@(posedge clk);
		#1;
		contact[i] = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		contact[i] = 1'b0;
	endtask : close
endmodule : frs_operator

// [verif/testbench.sv]
// self-checking bench of the fault restart supervisor
`timescale 1ns/1ps
module testbench;
	localparam int SEC = 20;
	localparam int SKIP = 10;
	localparam int CLR = 30;
	localparam int VHI = 40;
	logic        clk = 1'b0, rstn = 1'b0, ce = 1'b1, hv_variant = 1'b0, vin_low = 1'b0;
	logic        precharge_fail = 1'b1, comm_fail = 1'b0, cm_cable_lost = 1'b0, phase_loss = 1'b0;
	logic        at_max_speed = 1'b0, restart_enable = 1'b1, single_phase_supply_permit = 1'b0;
	logic [9:0]  vin_rms = 10'h0E6, bus_vdc = 10'h12C, bus_upper = 10'h12C, bus_lower = 10'h12C;
	logic [9:0]  pressure = 10'h064, setpoint = 10'h064, broken_pipe_threshold = 10'h032;
	logic [7:0]  gf_level = 8'h00, cur_unbal_pct = 8'h00, restart_delay_s = 8'h02;
	logic [7:0]  gf_sensitivity = 8'h32, current_unbalance_limit = 8'h0A;
	logic [3:0]  alarm_evt = 4'h0, alarm_as_fault = 4'h1, auto_restart_limit = 4'h0, log_sel = 4'h8;
	logic        key_up, key_down, key_enter, run_enable, auto_mode, init_fault;
	logic        restart_pending, prompt_enter, no_auto_msg;
	logic [3:0]  contact, fault_code, restart_count;
	logic [7:0]  countdown_s, log_count;
	logic [15:0] fault_latched;
	int          num_errors = 0, num_checks = 0;

	always #2.5 clk = ~clk;

	frs_operator op (.clk, .key_up, .key_down, .key_enter, .contact);
	frs_supervisor #(.SEC_CYC(SEC), .SKIP_CYC(SKIP), .CLR_CYC(CLR), .VIN_HI_CYC(VHI)) uut (
		.clk, .rstn, .ce, .key_up, .key_down, .key_enter, .dry_contact_input_1(contact[0]),
		.dry_contact_input_2(contact[1]), .dry_contact_input_3(contact[2]),
		.dry_contact_input_4(contact[3]), .hv_variant, .vin_rms, .vin_low, .bus_vdc, .bus_upper,
		.bus_lower, .precharge_fail, .comm_fail, .cm_cable_lost, .phase_loss, .gf_level,
		.cur_unbal_pct, .at_max_speed, .pressure, .setpoint, .alarm_evt, .restart_enable,
		.auto_restart_limit, .restart_delay_s, .gf_sensitivity, .current_unbalance_limit,
		.broken_pipe_threshold, .single_phase_supply_permit, .alarm_as_fault, .log_sel,
		.run_enable, .auto_mode, .init_fault, .restart_pending, .countdown_s, .prompt_enter,
		.no_auto_msg, .fault_code, .fault_latched, .restart_count, .log_count);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	// bounded wait for the drive to come back on
	task automatic wait_run(input int lim, output int n);
		n = 0;
		while (run_enable !== 1'b1 && n < lim) begin
			cyc(1);
			n++;
		end
	endtask : wait_run
	task automatic pulse_comm();
		comm_fail = 1'b1;
		cyc(1);
		comm_fail = 1'b0;
		cyc(2);
	endtask : pulse_comm
	task automatic t_init();
		int n;
		cyc(6);
		chk({15'h0, init_fault}, 16'h1);
		chk(fault_latched, 16'h0);
		chk({12'h0, fault_code}, 16'hE);
		precharge_fail = 1'b0;
		wait_run(10, n);
		cyc(2);
		chk({15'h0, run_enable}, 16'h1);
		chk({15'h0, auto_mode}, 16'h1);
		log_sel = 4'hE;
		cyc(1);
		chk({8'h0, log_count}, 16'h0);
		log_sel = 4'h8;
	endtask : t_init
	task automatic t_prompt();
		int n;
		pulse_comm();
		cyc(1);
		chk({14'h0, prompt_enter, restart_pending}, 16'h2);
		chk({12'h0, fault_code}, 16'h8);
		chk({8'h0, log_count}, 16'h1);
		op.press_enter();
		wait_run(20, n);
		chk({7'h0, run_enable, log_count}, 16'h100);
	endtask : t_prompt
	task automatic t_countdown();
		int n;
		auto_restart_limit = 4'h1;
		pulse_comm();
		chk({7'h0, restart_pending, countdown_s}, 16'h102);
		wait_run(4 * SEC, n);
		chk({15'h0, n >= 2 * SEC - 4 && n <= 2 * SEC + 4}, 16'h1);
		chk({12'h0, restart_count}, 16'h1);
		pulse_comm();
		cyc(1);
		chk({15'h0, prompt_enter}, 16'h1);
		op.press_enter();
		wait_run(20, n);
		chk({15'h0, run_enable}, 16'h1);
	endtask : t_countdown
	task automatic t_skip();
		int n;
		auto_restart_limit = 4'h3;
		restart_delay_s = 8'hC8;
		pulse_comm();
		op.hold_both(SKIP + 4);
		wait_run(10, n);
		chk({11'h0, run_enable, restart_count}, 16'h12);
		rstn = 1'b0;
		cyc(2);
		rstn = 1'b1;
		wait_run(10, n);
		chk({11'h0, run_enable, restart_count}, 16'h10);
	endtask : t_skip
	task automatic t_severe();
		int n;
		op.close(2);
		cyc(4);
		chk({14'h0, no_auto_msg, restart_pending}, 16'h2);
		chk(fault_latched, 16'h0008);
		op.hold_both(CLR / 2);
		cyc(4);
		chk({15'h0, no_auto_msg}, 16'h1);
		op.hold_both(CLR + 4);
		wait_run(10, n);
		chk({15'h0, run_enable}, 16'h1);
	endtask : t_severe
	// one condition per call, both sides of the low variant bus, unbalance and input high limits
	task automatic t_detect(input int k);
		int n;
		logic [15:0] exp;
		restart_enable = 1'b0;
		exp = 16'h0;
		case (k)
			0: {alarm_evt, exp} = {4'h1, 16'h0001};
			1: alarm_evt = 4'h2;
			2: {at_max_speed, setpoint, exp} = {1'b1, 10'h0C8, 16'h0020};
			3: {bus_vdc, exp} = {10'h1D6, 16'h0040};
			4: bus_vdc = 10'h1D5;
			5: {hv_variant, bus_vdc, exp} = {1'b1, 10'h3A2, 16'h0040};
			6: {bus_upper, bus_lower} = {10'h0C8, 10'h0B4};
			7: {bus_upper, bus_lower, exp} = {10'h0C8, 10'h0B3, 16'h0080};
			8: {comm_fail, exp} = {1'b1, 16'h0100};
			9: {cur_unbal_pct, exp} = {8'h14, 16'h0200};
			10: {cur_unbal_pct, current_unbalance_limit} = {8'h14, 8'h14};
			11: {gf_level, exp} = {8'h32, 16'h0400};
			12: {vin_rms, exp} = {10'h109, 16'h0800};
			13: {phase_loss, exp} = {1'b1, 16'h1000};
			14: {phase_loss, single_phase_supply_permit} = 2'h3;
			15: {cm_cable_lost, exp} = {1'b1, 16'h2000};
			16: {precharge_fail, exp} = {1'b1, 16'h4000};
			17: {vin_low, exp} = {1'b1, 16'h8000};
			default: vin_rms = 10'h108;
		endcase
		cyc((k == 12 || k == 18) ? VHI + 5 : 2);
		{alarm_evt, at_max_speed, hv_variant, comm_fail, phase_loss, cm_cable_lost} = '0;
		{precharge_fail, vin_low, single_phase_supply_permit, gf_level, cur_unbal_pct} = '0;
		{bus_vdc, bus_upper, bus_lower} = {3{10'h12C}};
		{setpoint, vin_rms, current_unbalance_limit} = {10'h064, 10'h0E6, 8'h0A};
		cyc(4);
		chk(fault_latched, exp);
		chk({14'h0, prompt_enter, no_auto_msg}, exp == 16'h0 ? 16'h0 :
			(|(exp & 16'h241E) ? 16'h1 : 16'h2));
		if (|(exp & 16'h241E)) begin
			op.hold_both(CLR + 4);
		end else if (exp != 16'h0) begin
			op.press_enter();
		end
		wait_run(CLR + 20, n);
		chk({15'h0, run_enable}, 16'h1);
	endtask : t_detect
	task automatic report_and_stop();
		if (num_errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		cyc(5);
		rstn = 1'b1;
		t_init();
		t_prompt();
		t_countdown();
		t_skip();
		t_severe();
		for (int k = 0; k < 19; k++) begin
			t_detect(k);
		end
		report_and_stop();
	end
	// about forty times the expected run length
	initial begin
		#100000;
		num_errors++;
		report_and_stop();
	end
endmodule : testbench
